/* flash_cmd_pkg.sv */
// How it works
// - A command is taken whether the serial clock idles low or high at chip select fall (modes 0 and 3).
// - Serial input is sampled on each rising serial clock edge, the host keeping it stable around that edge.
// - Commands other than status read are an 8-bit opcode, then 3 reserved bits, 12 page bits, 9 offset bits.
// - A page to buffer transfer or compare stays busy at most 250 us, or 300 us on the low-voltage part.
// - Erase plus program lasts 20 ms, program alone 14 ms, page erase 8 ms, block erase 12 ms, busy held until done.
// - Legacy opcodes 68H and 52H start a continuous array read and a page read.
// - Legacy opcodes 54H and 56H read buffer one and two, and 57H returns the status byte.
// - Opcodes E8H and D2H start a continuous array read and a page read like their legacy twins.
// - Opcodes D4H and D6H read buffer one and two, and D7H returns the status byte.
// - A continuous read runs past the last byte of a page into byte 0 of the next page.
package flash_cmd_pkg;

  // ****************************************
  // Clock and framing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int PAGE_W = 12;
  localparam int OFF_W = 9;
  localparam int CNT_W = 7;
  localparam int TIMER_W = 22;
  localparam logic [CNT_W-1:0] OP_LAST_BIT = 7'h07;
  localparam logic [CNT_W-1:0] HDR_LAST_BIT = 7'h1F;
  localparam logic [CNT_W-1:0] START_ARRAY = 7'h40;
  localparam logic [CNT_W-1:0] START_BUFFER = 7'h28;
  localparam logic [OFF_W-1:0] LAST_OFFSET = 9'h107;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_CONT_LEGACY = 8'h68;
  localparam logic [7:0] OP_PAGE_LEGACY = 8'h52;
  localparam logic [7:0] OP_BUF1_LEGACY = 8'h54;
  localparam logic [7:0] OP_BUF2_LEGACY = 8'h56;
  localparam logic [7:0] OP_STAT_LEGACY = 8'h57;
  localparam logic [7:0] OP_CONT_SPI = 8'hE8;
  localparam logic [7:0] OP_PAGE_SPI = 8'hD2;
  localparam logic [7:0] OP_BUF1_SPI = 8'hD4;
  localparam logic [7:0] OP_BUF2_SPI = 8'hD6;
  localparam logic [7:0] OP_STAT_SPI = 8'hD7;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_PAGE_TO_BUF1 = 8'h53;
  localparam logic [7:0] OP_PAGE_TO_BUF2 = 8'h55;
  localparam logic [7:0] OP_REWRITE1 = 8'h58;
  localparam logic [7:0] OP_REWRITE2 = 8'h59;
  localparam logic [7:0] OP_COMPARE1 = 8'h60;
  localparam logic [7:0] OP_COMPARE2 = 8'h61;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_PROG_VIA_BUF1 = 8'h82;
  localparam logic [7:0] OP_BUF1_TO_PAGE_ERASE = 8'h83;
  localparam logic [7:0] OP_PROG_VIA_BUF2 = 8'h85;
  localparam logic [7:0] OP_BUF2_TO_PAGE_ERASE = 8'h86;
  localparam logic [7:0] OP_BUF1_TO_PAGE = 8'h88;
  localparam logic [7:0] OP_BUF2_TO_PAGE = 8'h89;

  // ****************************************
  // Self-timed durations
  // ****************************************
  localparam int XFR_STD_US = 250;
  localparam int XFR_LV_US = 300;
  localparam int EP_MS = 20;
  localparam int P_MS = 14;
  localparam int PE_MS = 8;
  localparam int BE_MS = 12;
  localparam int XFR_STD_CYCLES = XFR_STD_US * CLK_MHZ;
  localparam int XFR_LV_CYCLES = XFR_LV_US * CLK_MHZ;
  localparam int EP_CYCLES_DEF = EP_MS * 1000 * CLK_MHZ;
  localparam int P_CYCLES_DEF = P_MS * 1000 * CLK_MHZ;
  localparam int PE_CYCLES_DEF = PE_MS * 1000 * CLK_MHZ;
  localparam int BE_CYCLES_DEF = BE_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {SRC_MAIN = 2'h0, SRC_BUF1 = 2'h1, SRC_BUF2 = 2'h2, SRC_STATUS = 2'h3} source_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_HEADER = 5'h02, ST_DUMMY = 5'h04, ST_DATA = 5'h08, ST_IGNORE = 5'h10
  } state_t;

  // Opcode decoding shared by the capture logic and its checks
  function automatic logic isStatusOp(input logic [7:0] op);
    return op == OP_STAT_LEGACY || op == OP_STAT_SPI;
  endfunction

  function automatic logic isContOp(input logic [7:0] op);
    return op == OP_CONT_LEGACY || op == OP_CONT_SPI;
  endfunction

  function automatic logic isPageOp(input logic [7:0] op);
    return op == OP_PAGE_LEGACY || op == OP_PAGE_SPI;
  endfunction

  function automatic logic isBufReadOp(input logic [7:0] op);
    return op == OP_BUF1_LEGACY || op == OP_BUF2_LEGACY || op == OP_BUF1_SPI || op == OP_BUF2_SPI;
  endfunction

  function automatic source_t readSource(input logic [7:0] op);
    if (op == OP_BUF1_LEGACY || op == OP_BUF1_SPI) begin
      return SRC_BUF1;
    end
    if (op == OP_BUF2_LEGACY || op == OP_BUF2_SPI) begin
      return SRC_BUF2;
    end
    return SRC_MAIN;
  endfunction

endpackage

/* flash_host_model.sv */
module flash_host_model (
  output logic csN, // Chip select to the device
  output logic sck, // Serial clock to the device
  output logic si, // Serial data to the device
  input wire logic so, // Serial data pin from the device
  input wire logic clk, // System clock, used only to pick a start phase
  output logic [7:0] rxByte, // Last byte received
  output logic rxToggle // Flips once per received byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Idle state
  // ****************************************
  // Deselected from time zero, so no command can straddle a reset
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rxByte = 8'h00;
    rxToggle = 1'b0;
  end

  // ****************************************
  // One framed command
  // ****************************************
  // Read bits are taken just before the next fall, inside the output hold window, not at the rise
  task automatic xfer(input logic mode3, input logic [31:0] hdr, input int hLen, input int nBytes);
    int total;
    logic [7:0] sh;
    total = hLen + 8 * nBytes;
    sh = 8'h00;
    @(negedge clk);
    sck = mode3;
    csN = 1'b0;
    #256;
    for (int c = 0; c <= total; c++) begin
      if (c > hLen) begin
        sh = {sh[6:0], so};
        if ((c - hLen) % 8 == 0) begin
          rxByte = sh;
          rxToggle = ~rxToggle;
        end
      end
      if (c == total) begin
        break;
      end
      sck = 1'b0;
      si = (c < hLen && c < 32) ? hdr[31 - c] : 1'($urandom_range(1));
      #32;
      sck = 1'b1;
      #32;
    end
    sck = mode3;
    #256;
    csN = 1'b1;
    si = ~si; // Released line shows no stale value
    #256;
  endtask
endmodule

/* flash_stream_fifo.sv */
module flash_stream_fifo
  import flash_cmd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic clear, // Drops all content
  input wire logic [WIDTH-1:0] wrData, // Word to store
  input wire logic wrValid, // Word offered
  output logic wrReady, // Room for a word
  output logic [WIDTH-1:0] rdData, // Oldest word
  output logic rdValid, // A word is held
  input wire logic rdReady // Oldest word taken
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire push = wrValid && wrReady;
  wire pop = rdValid && rdReady;

  // Extra pointer bit tells full from empty
  assign wrReady = !(wrPtr[AW] != rdPtr[AW] && wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign rdValid = wrPtr != rdPtr;
  assign rdData = mem[rdPtr[AW-1:0]];

  // Pointers
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  // Storage needs no reset; only words below the write pointer are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= wrData;
    end
  end

  fifo_no_overrun_a: assert property (@(posedge clk) disable iff (rst) !wrReady |=> !wrReady || $past(pop) || $past(clear))
    else $error("fifo room appeared without a pop");

endmodule

/* serial_flash_command_port.sv */
module serial_flash_command_port
  import flash_cmd_pkg::*;
#(
  parameter int XFR_CYCLES = XFR_STD_CYCLES,
  parameter int EP_CYCLES = EP_CYCLES_DEF,
  parameter int P_CYCLES = P_CYCLES_DEF,
  parameter int PE_CYCLES = PE_CYCLES_DEF,
  parameter int BE_CYCLES = BE_CYCLES_DEF
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic csN, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial input pin
  input wire logic resetN, // Reset pin, active low
  output logic soBit, // Serial output level
  output logic soOe, // Serial output driven
  output logic readyBusy, // High when ready
  output logic fetchValid, // Read data wanted
  output source_t fetchSource, // Array or buffer to read
  output logic [PAGE_W-1:0] fetchPage, // Page of next byte
  output logic [OFF_W-1:0] fetchOffset, // Offset of next byte
  input wire logic [7:0] fillData, // Byte at fetch address
  input wire logic fillValid, // Byte offered
  output logic fillReady, // Byte taken this cycle
  input wire logic [6:0] deviceStatus, // Low status bits
  output logic opStart, // Self-timed operation launched
  output logic [7:0] opCode // Opcode of last command
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic csMeta, csSync, csLast;
  logic sckMeta, sckSync, sckLast;
  logic siMeta, siSync;
  logic rstnMeta, rstnSync;

  // Two flops per pin; edge detection looks only at the second and later
  always_ff @(posedge clk) begin
    if (rst) begin
      {csMeta, csSync, csLast} <= 3'h7;
      {sckMeta, sckSync, sckLast} <= 3'h0;
      {siMeta, siSync} <= 2'h0;
      {rstnMeta, rstnSync} <= 2'h0;
    end else begin
      {csMeta, csSync, csLast} <= {csN, csMeta, csSync};
      {sckMeta, sckSync, sckLast} <= {sck, sckMeta, sckSync};
      {siMeta, siSync} <= {si, siMeta};
      {rstnMeta, rstnSync} <= {resetN, rstnMeta};
    end
  end

  // Edges; the idle level of the clock at select is never looked at
  wire csFall = csLast && !csSync;
  wire csRise = !csLast && csSync;
  wire sckRise = sckSync && !sckLast && !csSync;
  wire sckFall = !sckSync && sckLast && !csSync;
  wire abort = !rstnSync;

  // ****************************************
  // Command capture
  // ****************************************
  state_t state;
  logic [CNT_W-1:0] bitCount;
  logic [31:0] hdr;
  logic [CNT_W-1:0] dataStart;
  logic continuous;
  logic busy;
  logic [TIMER_W-1:0] timer;

  wire [31:0] nextHdr = {hdr[30:0], siSync};
  wire opDone = state == ST_HEADER && sckRise && bitCount == OP_LAST_BIT;
  wire hdrDone = state == ST_HEADER && sckRise && bitCount == HDR_LAST_BIT;
  wire [7:0] newOp = nextHdr[7:0];
  wire opIsRead = isContOp(opCode) || isPageOp(opCode) || isBufReadOp(opCode);
  wire dummyDone = state == ST_DUMMY && sckRise && bitCount == dataStart - 1'b1;
  wire fillAccept = fillValid && fillReady;
  wire offsetWrap = fetchOffset == LAST_OFFSET;

  // Header shifting and phase steps; the reserved bits nextHdr[23:21] are dropped
  always_ff @(posedge clk) begin
    if (rst || abort || csSync) begin
      state <= ST_IDLE;
      bitCount <= '0;
    end else if (csFall || state == ST_IDLE) begin
      state <= ST_HEADER;
      bitCount <= '0;
    end else if (sckRise && state != ST_DATA && state != ST_IGNORE) begin
      bitCount <= bitCount + 1'b1;
      hdr <= nextHdr;
      if (opDone && isStatusOp(newOp)) begin
        state <= ST_DATA;
      end else if (hdrDone) begin
        state <= opIsRead ? ST_DUMMY : ST_IGNORE;
      end else if (dummyDone) begin
        state <= ST_DATA;
      end
    end
  end

  // Opcode decode picks source, dummy length and page crossing
  always_ff @(posedge clk) begin
    if (rst) begin
      opCode <= '0;
      fetchSource <= SRC_MAIN;
      continuous <= 1'b0;
      dataStart <= START_ARRAY;
    end else if (opDone) begin
      opCode <= newOp;
      fetchSource <= isStatusOp(newOp) ? SRC_STATUS : readSource(newOp);
      continuous <= isContOp(newOp);
      dataStart <= isBufReadOp(newOp) ? START_BUFFER : START_ARRAY;
    end
  end

  // Address register walks one byte per byte fetched
  always_ff @(posedge clk) begin
    if (rst) begin
      fetchPage <= '0;
      fetchOffset <= '0;
    end else if (hdrDone) begin
      fetchPage <= nextHdr[20:9];
      fetchOffset <= nextHdr[8:0];
    end else if (fillAccept) begin
      fetchOffset <= offsetWrap ? '0 : fetchOffset + 1'b1;
      if (offsetWrap && continuous) begin
        fetchPage <= fetchPage + 1'b1;
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  logic fifoReady, fifoValid;
  logic [7:0] fifoData;
  logic [7:0] outShift;
  logic [2:0] outBit;

  assign fetchValid = (state == ST_DUMMY || state == ST_DATA) && fetchSource != SRC_STATUS;
  assign fillReady = fetchValid && fifoReady;
  wire loadByte = state == ST_DATA && sckFall && outBit == 3'h0;
  wire [7:0] statusByte = {readyBusy, deviceStatus};
  wire [7:0] arrayByte = fifoValid ? fifoData : IDLE_BYTE; // Underrun shows as all ones
  wire [7:0] sendByte = fetchSource == SRC_STATUS ? statusByte : arrayByte;
  wire popByte = loadByte && fetchSource != SRC_STATUS;

  // Prefetch runs during the dummy bytes so the first byte waits in the FIFO
  flash_stream_fifo #(.WIDTH(8), .DEPTH(8)) prefetch (
    .clk(clk),
    .rst(rst),
    .clear(csSync),
    .wrData(fillData),
    .wrValid(fillValid && fetchValid),
    .wrReady(fifoReady),
    .rdData(fifoData),
    .rdValid(fifoValid),
    .rdReady(popByte)
  );

  // Bits leave on falling edges so they are settled for the host's rising edge
  always_ff @(posedge clk) begin
    if (rst || abort || csSync) begin
      soOe <= 1'b0;
      soBit <= 1'b0;
      outBit <= '0;
      outShift <= '0;
    end else if (state == ST_DATA && sckFall) begin
      soOe <= 1'b1;
      outBit <= outBit + 1'b1;
      soBit <= loadByte ? sendByte[7] : outShift[7];
      outShift <= loadByte ? {sendByte[6:0], 1'b0} : {outShift[6:0], 1'b0};
    end
  end

  // ****************************************
  // Self-timed operations
  // ****************************************
  function automatic logic [TIMER_W-1:0] opDuration(input logic [7:0] op);
    unique case (op)
      OP_PAGE_TO_BUF1, OP_PAGE_TO_BUF2, OP_COMPARE1, OP_COMPARE2: return TIMER_W'(XFR_CYCLES);
      OP_PROG_VIA_BUF1, OP_PROG_VIA_BUF2, OP_BUF1_TO_PAGE_ERASE,
      OP_BUF2_TO_PAGE_ERASE, OP_REWRITE1, OP_REWRITE2: return TIMER_W'(EP_CYCLES);
      OP_BUF1_TO_PAGE, OP_BUF2_TO_PAGE: return TIMER_W'(P_CYCLES);
      OP_PAGE_ERASE: return TIMER_W'(PE_CYCLES);
      OP_BLOCK_ERASE: return TIMER_W'(BE_CYCLES);
      default: return '0;
    endcase
  endfunction

  wire [TIMER_W-1:0] launchCycles = opDuration(opCode);
  // A launch while busy is dropped: the array can run only one job
  wire launch = csRise && state == ST_IGNORE && launchCycles != '0 && !busy;

  // Busy timer counts the operation's full length down to zero
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      busy <= 1'b0;
      timer <= '0;
      opStart <= 1'b0;
    end else begin
      opStart <= launch;
      if (launch) begin
        busy <= 1'b1;
        timer <= launchCycles - 1'b1;
      end else if (busy) begin
        busy <= timer != '0;
        timer <= timer - (timer != '0);
      end
    end
  end

  assign readyBusy = !busy;

  // ****************************************
  // Checks
  // ****************************************
  so_float_a: assert property (@(posedge clk) disable iff (rst) csSync |=> !soOe)
    else $error("serial output driven with select high");
  no_drive_early_a: assert property (@(posedge clk) disable iff (rst) $rose(soOe) |-> $past(state) == ST_DATA)
    else $error("serial output driven outside data phase");
  mode_fall_a: assert property (@(posedge clk) disable iff (rst)
    (sckFall && state != ST_DATA) |=> $stable(soBit))
    else $error("falling clock moved output outside data");
  addr_capture_a: assert property (@(posedge clk) disable iff (rst)
    hdrDone |=> fetchPage == $past(nextHdr[20:9]) && fetchOffset == $past(nextHdr[8:0]))
    else $error("page or offset captured wrongly");
  status_now_a: assert property (@(posedge clk) disable iff (rst)
    (opDone && isStatusOp(newOp) && !abort) |=> state == ST_DATA && fetchSource == SRC_STATUS)
    else $error("status read did not start data");
  array_dummy_a: assert property (@(posedge clk) disable iff (rst)
    (dummyDone && !abort) |-> bitCount == (isBufReadOp(opCode) ? START_BUFFER : START_ARRAY) - 1'b1)
    else $error("dummy length wrong for opcode");
  cont_wrap_a: assert property (@(posedge clk) disable iff (rst)
    (fillAccept && continuous && offsetWrap) |=> fetchOffset == '0 && fetchPage == PAGE_W'($past(fetchPage) + 1'b1))
    else $error("continuous read failed to enter next page");
  page_wrap_a: assert property (@(posedge clk) disable iff (rst)
    (fillAccept && !continuous && offsetWrap) |=> fetchOffset == '0 && $stable(fetchPage))
    else $error("page read left its page");
  launch_busy_a: assert property (@(posedge clk) disable iff (rst) opStart |-> busy && !$past(busy))
    else $error("launch did not raise busy");
  ep_time_a: assert property (@(posedge clk) disable iff (rst)
    (opStart && (opCode == OP_BUF1_TO_PAGE_ERASE || opCode == OP_BUF2_TO_PAGE_ERASE ||
    opCode == OP_PROG_VIA_BUF1 || opCode == OP_PROG_VIA_BUF2 ||
    opCode == OP_REWRITE1 || opCode == OP_REWRITE2)) |-> timer == TIMER_W'(EP_CYCLES - 1))
    else $error("erase and program length wrong");
  xfr_time_a: assert property (@(posedge clk) disable iff (rst)
    (opStart && opCode == OP_PAGE_TO_BUF1) |-> timer == TIMER_W'(XFR_CYCLES - 1))
    else $error("transfer length wrong");
  ready_back_a: assert property (@(posedge clk) disable iff (rst)
    (busy && timer == '0 && !abort) |=> !busy)
    else $error("busy outlived its timer");

endmodule

/* tb_top.sv */
`define CHK(got, exp, what) begin totalChecks++; if ((got) !== (exp)) begin errTotal++; \
$display("BAD %0t %s: got %0h expected %0h", $time, what, got, exp); end end

module tb_top
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Design, host and fetch side
  // ****************************************
  localparam int SIM_XFR = 40;
  localparam int SIM_EP = 3000;
  localparam int SIM_P = 50;
  localparam int SIM_PE = 30;
  localparam int SIM_BE = 45;
  logic clk = 1'b0;
  logic rst;
  logic resetN;
  wire csN;
  wire sck;
  wire si;
  wire so;
  wire [7:0] rxByte;
  wire rxToggle;
  logic soBit, soOe, readyBusy, fetchValid, fillReady, opStart, fillValid;
  source_t fetchSource;
  logic [PAGE_W-1:0] fetchPage;
  logic [OFF_W-1:0] fetchOffset;
  logic [7:0] fillData;
  logic [6:0] deviceStatus;
  logic [7:0] opCode;
  logic [31:0] expQ [$];
  int errTotal = 0;
  int totalChecks = 0;
  int busyLen = 0;
  int opCount = 0;
  logic rxSeen = 1'b0;
  logic [7:0] rdOp [10] = '{OP_CONT_SPI, OP_CONT_LEGACY, OP_PAGE_SPI, OP_PAGE_LEGACY, OP_BUF1_SPI,
    OP_BUF2_SPI, OP_BUF1_LEGACY, OP_BUF2_LEGACY, OP_CONT_SPI, OP_PAGE_SPI};
  logic [11:0] rdPage [10] = '{12'h005, 12'hFFF, 12'h3C2, 12'h0A5, 12'h000, 12'h7FF, 12'h001, 12'h000,
    12'h123, 12'h800};
  logic [8:0] rdOff [10] = '{9'h105, 9'h106, 9'h106, 9'h000, 9'h107, 9'h0FE, 9'h010, 9'h105, 9'h100, 9'h050};
  int rdN [10] = '{5, 4, 4, 3, 3, 3, 2, 4, 12, 2};
  logic [7:0] opList [13] = '{OP_PAGE_TO_BUF1, OP_PAGE_TO_BUF2, OP_COMPARE1, OP_COMPARE2, OP_BUF1_TO_PAGE,
    OP_BUF2_TO_PAGE, OP_PAGE_ERASE, OP_BLOCK_ERASE, OP_PROG_VIA_BUF1, OP_PROG_VIA_BUF2, OP_BUF2_TO_PAGE_ERASE,
    OP_REWRITE1, OP_REWRITE2};
  int opLen [13] = '{SIM_XFR, SIM_XFR, SIM_XFR, SIM_XFR, SIM_P, SIM_P, SIM_PE, SIM_BE, SIM_EP, SIM_EP, SIM_EP,
    SIM_EP, SIM_EP};

  // No pull on the pin, so a floating output reads as unknown and fails
  assign so = soOe ? soBit : 1'bz;

  // 125 MHz system clock
  always #4 clk = ~clk;

  serial_flash_command_port #(.XFR_CYCLES(SIM_XFR), .EP_CYCLES(SIM_EP), .P_CYCLES(SIM_P),
    .PE_CYCLES(SIM_PE), .BE_CYCLES(SIM_BE)) u_dut (.clk(clk), .rst(rst), .csN(csN), .sck(sck), .si(si),
    .resetN(resetN), .soBit(soBit), .soOe(soOe), .readyBusy(readyBusy), .fetchValid(fetchValid),
    .fetchSource(fetchSource), .fetchPage(fetchPage), .fetchOffset(fetchOffset), .fillData(fillData),
    .fillValid(fillValid), .fillReady(fillReady), .deviceStatus(deviceStatus), .opStart(opStart),
    .opCode(opCode));

  flash_host_model u_host (.csN(csN), .sck(sck), .si(si), .so(so), .clk(clk), .rxByte(rxByte),
    .rxToggle(rxToggle));

  // Byte the fetch side holds at each address; buffers ignore the page
  function automatic logic [7:0] fillFor(input source_t src, input logic [11:0] pg, input logic [8:0] of);
    logic [7:0] mix;
    mix = (src == SRC_MAIN) ? pg[7:0] + {pg[11:8], 4'h5} : 8'h00;
    return of[7:0] ^ {of[8], 1'b0, src, 4'h0} ^ mix;
  endfunction

  function automatic source_t srcOf(input logic [7:0] op);
    case (op)
      OP_BUF1_SPI, OP_BUF1_LEGACY: return SRC_BUF1;
      OP_BUF2_SPI, OP_BUF2_LEGACY: return SRC_BUF2;
      default: return SRC_MAIN;
    endcase
  endfunction

  // Random stalls slow the fill, yet it still outruns the serial side, so the FIFO stays near full
  always @(negedge clk) begin
    fillValid <= ($urandom_range(3) != 0);
    fillData <= fillFor(fetchSource, fetchPage, fetchOffset);
  end

  task automatic printVerdict();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic takeNote(input logic [31:0] got, input string what);
    logic [31:0] want;
    if (expQ.size() == 0) begin
      errTotal++;
      $display("BAD %0t %s with nothing expected", $time, what);
    end else begin
      want = expQ.pop_front();
      `CHK(got, want, what)
    end
  endtask

  // ****************************************
  // Result watcher
  // ****************************************
  // Notes must be queued in the order results appear: bytes and busy lengths share one queue
  always @(posedge clk) begin
    if (opStart === 1'b1) begin
      opCount++;
    end
    if (rxToggle !== rxSeen) begin
      rxSeen = rxToggle;
      takeNote({24'h0, rxByte}, "read byte");
    end
    if (rst) begin
      busyLen = 0;
    end else if (readyBusy !== 1'b1) begin
      busyLen++;
    end else if (busyLen != 0) begin
      takeNote(32'(busyLen), "busy length");
      busyLen = 0;
    end
  end

  task automatic waitReady();
    int n;
    n = 0;
    while (readyBusy !== 1'b1 || busyLen != 0) begin
      @(negedge clk);
      n++;
      if (n > 5000) begin
        errTotal++;
        $display("BAD %0t ready never returned", $time);
        printVerdict();
      end
    end
    @(negedge clk);
  endtask

  // Hang guard
  initial begin
    #700000;
    errTotal++;
    $display("BAD %0t run limit reached", $time);
    printVerdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] op;
    logic [11:0] pg;
    logic [8:0] of;
    logic [31:0] hdr;
    source_t src;
    int n;
    void'($urandom(87395));
    rst = 1'b1;
    resetN = 1'b1;
    fillData = 8'h00;
    fillValid = 1'b0;
    deviceStatus = 7'h00;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    // Reads of every kind, page ends and the top page included, then random ones
    for (int i = 0; i < 14; i++) begin
      op = (i < 10) ? rdOp[i] : rdOp[$urandom_range(7)];
      pg = (i < 10) ? rdPage[i] : 12'($urandom);
      of = (i < 10) ? rdOff[i] : 9'($urandom_range(263));
      n = (i < 10) ? rdN[i] : 3;
      src = srcOf(op);
      hdr = {op, 3'b000, pg, of};
      for (int k = 0; k < n; k++) begin
        expQ.push_back({24'h0, fillFor(src, pg, of)});
        if (of == 9'h107) begin
          of = 9'h000;
          pg = (op == OP_CONT_SPI || op == OP_CONT_LEGACY) ? pg + 12'h001 : pg;
        end else begin
          of = of + 9'h001;
        end
      end
      u_host.xfer(1'(i % 2), hdr, (src == SRC_MAIN) ? 64 : 40, n);
      `CHK(soOe, 1'b0, "output after deselect")
      `CHK(opCode, op, "opcode")
    end
    // Status byte in both sets, repeated while clocked
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      deviceStatus = 7'($urandom);
      expQ.push_back({24'h0, 1'b1, deviceStatus});
      expQ.push_back({24'h0, 1'b1, deviceStatus});
      u_host.xfer(1'(i / 2), {(i % 2) ? OP_STAT_LEGACY : OP_STAT_SPI, 24'h000000}, 8, 2);
    end
    // Self-timed operations, busy length measured
    for (int i = 0; i < 13; i++) begin
      expQ.push_back(32'(opLen[i]));
      u_host.xfer(1'(i % 2), {opList[i], 3'b000, 12'($urandom), 9'($urandom_range(263))}, 32, 0);
      waitReady();
      `CHK(opCode, opList[i], "op opcode")
    end
    // Long operation: status shows busy, a second launch is dropped
    @(negedge clk);
    deviceStatus = 7'($urandom);
    expQ.push_back({24'h0, 1'b0, deviceStatus});
    expQ.push_back(32'(SIM_EP));
    u_host.xfer(1'b0, {OP_BUF1_TO_PAGE_ERASE, 3'b000, 12'h2A7, 9'h000}, 32, 0);
    u_host.xfer(1'b1, {OP_BUF2_TO_PAGE, 3'b000, 12'h2A8, 9'h000}, 32, 0);
    u_host.xfer(1'b0, {OP_STAT_SPI, 24'h000000}, 8, 1);
    waitReady();
    `CHK(opCount, 14, "launch count")
    `CHK(expQ.size(), 0, "results left")
    printVerdict();
  end
endmodule
